// File: src/byte_op_pkg.sv
// Package with opcodes, field positions, widths and reset values of the byte-op and branch unit.
package byte_op_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int LIT_W = 11;
    localparam int PC_W = 13;
    localparam int LATCH_W = 8;
    localparam int INSTR_W = 14;
    // Opcode fields, upper six bits for file ops, upper three for the branch.
    localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
    localparam logic [5:0] OPC_DECREMENT = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
    localparam logic [5:0] OPC_CLEAR = 6'h01;
    localparam logic [2:0] OPC_BRANCH = 3'h5;
    // Field positions inside the instruction word, the upper latch and the program counter.
    localparam int DEST_BIT = 7;
    localparam int FADDR_LSB = 0;
    localparam int LIT_LSB = 0;
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;
    localparam int PC_UPPER_LSB = 11;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [FADDR_W-1:0] RESET_FADDR = 7'h00;
    localparam logic [PC_W-1:0] RESET_PC = 13'h0000;
    localparam logic [1:0] RESET_FLUSH = 2'h0;
    typedef enum {
        OP_NONE,
        OP_COMPLEMENT,
        OP_CLEAR_FILE,
        OP_DECREMENT,
        OP_CLEAR_WORKING,
        OP_DEC_SKIP,
        OP_BRANCH
    } op_kind_t;
endpackage : byte_op_pkg

// File: src/op_classifier.sv
// Instruction classifier that names the operation and splits its operand fields.
`timescale 1ns/100ps
`default_nettype none
module op_classifier
    import byte_op_pkg::*;
(
    // Instruction word.
    input wire logic [byte_op_pkg::INSTR_W-1:0] instr,
    // Decoded fields.
    output byte_op_pkg::op_kind_t kind,
    output logic dest_file,
    output logic [byte_op_pkg::FADDR_W-1:0] faddr,
    output logic [byte_op_pkg::LIT_W-1:0] literal
);
    always_comb begin
        dest_file = instr[DEST_BIT];
        faddr = instr[FADDR_LSB +: FADDR_W];
        literal = instr[LIT_LSB +: LIT_W];
        kind = OP_NONE;
        if (instr[13:11] == OPC_BRANCH) begin
            kind = OP_BRANCH;
        end else begin
            case (instr[13:8])
                OPC_COMPLEMENT: kind = OP_COMPLEMENT;
                OPC_DECREMENT: kind = OP_DECREMENT;
                OPC_DEC_SKIP: kind = OP_DEC_SKIP;
                OPC_CLEAR: kind = instr[DEST_BIT] ? OP_CLEAR_FILE : OP_CLEAR_WORKING;
                default: kind = OP_NONE;
            endcase
        end
    end
endmodule : op_classifier
`default_nettype wire

// File: src/byte_op_and_branch_exec.sv
// Execution unit for complement, clear, decrement, decrement-and-skip and absolute branch.
`timescale 1ns/100ps
`default_nettype none
module byte_op_and_branch_exec
    import byte_op_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Instruction issue.
    input wire logic instr_valid,
    input wire logic [byte_op_pkg::INSTR_W-1:0] instr,
    input wire logic [byte_op_pkg::DATA_W-1:0] file_rdata,
    input wire logic [byte_op_pkg::LATCH_W-1:0] program_counter_upper_latch,
    // Result to the file register.
    output logic file_we,
    output logic [byte_op_pkg::FADDR_W-1:0] file_waddr,
    output logic [byte_op_pkg::DATA_W-1:0] file_wdata,
    output logic [byte_op_pkg::FADDR_W-1:0] file_raddr,
    // Result to the working register and the zero flag.
    output logic working_we,
    output logic [byte_op_pkg::DATA_W-1:0] working_wdata,
    output logic zero_we,
    output logic zero_value,
    // Program flow.
    output logic pc_load,
    output logic [byte_op_pkg::PC_W-1:0] program_counter,
    output logic flush,
    output logic no_operation
);
    import byte_op_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    op_kind_t kind;
    logic dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [LIT_W-1:0] literal;

    op_classifier u_class (
        .instr(instr),
        .kind(kind),
        .dest_file(dest_file),
        .faddr(faddr),
        .literal(literal)
    );

    function automatic logic [DATA_W-1:0] dec_byte(input logic [DATA_W-1:0] v);
        dec_byte = v - 8'h01;
    endfunction : dec_byte

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    logic [1:0] flush_pending;
    logic squash;
    logic live;
    logic [DATA_W-1:0] result;
    logic res_to_file;
    logic res_to_work;
    logic set_zero;
    logic zero_val;
    logic branch;
    logic skip;
    logic [PC_W-1:0] target;

    assign squash = (flush_pending != RESET_FLUSH);
    assign live = instr_valid && !squash;
    assign file_raddr = faddr;

    always_comb begin
        result = ZERO_BYTE;
        res_to_file = 1'b0;
        res_to_work = 1'b0;
        set_zero = 1'b0;
        zero_val = 1'b0;
        branch = 1'b0;
        skip = 1'b0;
        target = {program_counter_upper_latch[LATCH_HI:LATCH_LO], literal};
        if (live) begin
            case (kind)
                OP_COMPLEMENT: begin
                    result = ~file_rdata;
                    res_to_file = dest_file;
                    res_to_work = !dest_file;
                    set_zero = 1'b1;
                    zero_val = (result == ZERO_BYTE);
                end
                OP_CLEAR_FILE: begin
                    result = ZERO_BYTE;
                    res_to_file = 1'b1;
                    set_zero = 1'b1;
                    zero_val = 1'b1;
                end
                OP_DECREMENT: begin
                    result = dec_byte(file_rdata);
                    res_to_file = dest_file;
                    res_to_work = !dest_file;
                    set_zero = 1'b1;
                    zero_val = (result == ZERO_BYTE);
                end
                OP_CLEAR_WORKING: begin
                    result = ZERO_BYTE;
                    res_to_work = 1'b1;
                    set_zero = 1'b1;
                    zero_val = 1'b1;
                end
                OP_DEC_SKIP: begin
                    result = dec_byte(file_rdata);
                    res_to_file = dest_file;
                    res_to_work = !dest_file;
                    skip = (result == ZERO_BYTE);
                end
                OP_BRANCH: begin
                    branch = 1'b1;
                end
                default: begin
                    result = ZERO_BYTE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic [1:0] next_flush_pending;
    logic next_file_we;
    logic next_working_we;
    logic next_zero_we;
    logic next_zero_value;
    logic next_pc_load;
    logic [PC_W-1:0] next_program_counter;
    logic [FADDR_W-1:0] next_file_waddr;
    logic [DATA_W-1:0] next_file_wdata;
    logic [DATA_W-1:0] next_working_wdata;
    logic next_flush;
    logic next_no_operation;

    always_comb begin
        next_flush_pending = 2'h0;
        if (instr_valid) begin
            if (squash) begin
                next_flush_pending = flush_pending - 2'h1;
            end else if (branch || skip) begin
                next_flush_pending = 2'h1;
            end
        end else begin
            next_flush_pending = flush_pending;
        end
        next_file_we = res_to_file;
        next_file_waddr = faddr;
        next_file_wdata = result;
        next_working_we = res_to_work;
        next_working_wdata = result;
        next_zero_we = set_zero;
        next_zero_value = zero_val;
        next_pc_load = branch;
        next_program_counter = branch ? target : program_counter;
        next_flush = branch || skip;
        next_no_operation = instr_valid && squash;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flush_pending <= RESET_FLUSH;
            file_we <= 1'b0;
            file_waddr <= RESET_FADDR;
            file_wdata <= RESET_BYTE;
            working_we <= 1'b0;
            working_wdata <= RESET_BYTE;
            zero_we <= 1'b0;
            zero_value <= 1'b0;
            pc_load <= 1'b0;
            program_counter <= RESET_PC;
            flush <= 1'b0;
            no_operation <= 1'b0;
        end else if (ce) begin
            flush_pending <= next_flush_pending;
            file_we <= next_file_we;
            file_waddr <= next_file_waddr;
            file_wdata <= next_file_wdata;
            working_we <= next_working_we;
            working_wdata <= next_working_wdata;
            zero_we <= next_zero_we;
            zero_value <= next_zero_value;
            pc_load <= next_pc_load;
            program_counter <= next_program_counter;
            flush <= next_flush;
            no_operation <= next_no_operation;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_live_op(op_kind_t k);
        ce && live && kind == k;
    endsequence

    chk_complement_result: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_COMPLEMENT) |=> (file_wdata == ~$past(file_rdata)) && (file_we == $past(dest_file))
            && (working_we != file_we))
        else $error("complement result or routing wrong");
    chk_clear_file_zero: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_CLEAR_FILE) |=> file_we && file_wdata == ZERO_BYTE && zero_we && zero_value)
        else $error("clear file did not zero the file and set zero");
    chk_decrement_zero: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_DECREMENT) |=> zero_we && (file_wdata == $past(file_rdata) - 8'h01)
            && (zero_value == ($past(file_rdata) == 8'h01)))
        else $error("decrement result or zero flag wrong");
    chk_clear_working: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_CLEAR_WORKING) |=> working_we && working_wdata == ZERO_BYTE && zero_value && !file_we)
        else $error("clear working failed");
    chk_skip_no_zero: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_DEC_SKIP) |=> !zero_we && (file_wdata == $past(file_rdata) - 8'h01))
        else $error("decrement-and-skip touched zero flag or bad result");
    chk_skip_nonzero: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_DEC_SKIP) ##0 (file_rdata != 8'h01) |=> !flush && flush_pending == 2'h0)
        else $error("nonzero result caused a skip");
    chk_skip_squash: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_DEC_SKIP) ##0 (file_rdata == 8'h01) ##1 (ce && instr_valid) |=> no_operation && !file_we)
        else $error("zero result did not squash the next instruction");
    chk_branch_target: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_BRANCH) |=> pc_load && program_counter[10:0] == $past(instr[10:0])
            && program_counter[12:11] == $past(program_counter_upper_latch[4:3]))
        else $error("branch target wrong");
    chk_branch_flush: assert property (@(posedge clk) disable iff (rst)
        s_live_op(OP_BRANCH) ##1 (ce && instr_valid) |=> no_operation && !working_we && !pc_load)
        else $error("branch follower not flushed");
endmodule : byte_op_and_branch_exec
`default_nettype wire

// File: verif/test_byte_op_and_branch_exec.sv
// Self-checking testbench for the byte-op and branch execution unit.
`timescale 1ns/100ps
`default_nettype none
module test_byte_op_and_branch_exec;
    import byte_op_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, observed outputs and counters.
    // ------------------------------------------------------------
    logic clk;
    logic rst;
    logic ce;
    logic instr_valid;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0] file_rdata;
    logic [LATCH_W-1:0] program_counter_upper_latch;
    logic file_we;
    logic [FADDR_W-1:0] file_waddr;
    logic [DATA_W-1:0] file_wdata;
    logic [FADDR_W-1:0] file_raddr;
    logic working_we;
    logic [DATA_W-1:0] working_wdata;
    logic zero_we;
    logic zero_value;
    logic pc_load;
    logic [PC_W-1:0] program_counter;
    logic flush;
    logic no_operation;
    int bad_count;
    int cmp_count;

    byte_op_and_branch_exec i_byte_op_and_branch_exec (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
        .instr(instr), .file_rdata(file_rdata), .program_counter_upper_latch(program_counter_upper_latch),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .file_raddr(file_raddr),
        .working_we(working_we), .working_wdata(working_wdata), .zero_we(zero_we), .zero_value(zero_value),
        .pc_load(pc_load), .program_counter(program_counter), .flush(flush), .no_operation(no_operation));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Drives one instruction slot at the rising edge.
    task automatic put(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] rd, input logic v);
        @(posedge clk);
        instr <= w;
        file_rdata <= rd;
        instr_valid <= v;
    endtask : put

    // Order: file_we, working_we, zero_we, zero_value, pc_load, flush, no_operation.
    task automatic flags(input logic [6:0] exp);
        #1;
        check({9'h000, file_we, working_we, zero_we, zero_value, pc_load, flush, no_operation}, {9'h000, exp});
    endtask : flags

    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_complement;
        put({OPC_COMPLEMENT, 1'b0, 7'h7f}, 8'ha5, 1'b1);
        #1 check(16'(file_raddr), 16'h007f);
        put({OPC_COMPLEMENT, 1'b1, 7'h00}, 8'hff, 1'b1);
        flags(7'b0110000);
        check(16'(working_wdata), 16'h005a);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b1011000);
        check(16'(file_wdata), 16'h0000);
        check(16'(file_waddr), 16'h0000);
    endtask : t_complement

    task automatic t_clear;
        put({OPC_CLEAR, 1'b1, 7'h2a}, 8'h77, 1'b1);
        put({OPC_CLEAR, 1'b0, 7'h00}, 8'h55, 1'b1);
        flags(7'b1011000);
        check(16'(file_wdata), 16'h0000);
        check(16'(file_waddr), 16'h002a);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0111000);
        check(16'(working_wdata), 16'h0000);
    endtask : t_clear

    task automatic t_decrement;
        put({OPC_DECREMENT, 1'b0, 7'h10}, 8'h01, 1'b1);
        put({OPC_DECREMENT, 1'b1, 7'h11}, 8'h00, 1'b1);
        flags(7'b0111000);
        check(16'(working_wdata), 16'h0000);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b1010000);
        check(16'(file_wdata), 16'h00ff);
        check(16'(file_waddr), 16'h0011);
    endtask : t_decrement

    task automatic t_skip_nonzero;
        put({OPC_DEC_SKIP, 1'b1, 7'h05}, 8'h05, 1'b1);
        put({OPC_COMPLEMENT, 1'b0, 7'h06}, 8'h0f, 1'b1);
        flags(7'b1000000);
        check(16'(file_wdata), 16'h0004);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0110000);
        check(16'(working_wdata), 16'h00f0);
    endtask : t_skip_nonzero

    task automatic t_skip_zero;
        put({OPC_DEC_SKIP, 1'b0, 7'h05}, 8'h01, 1'b1);
        put({OPC_COMPLEMENT, 1'b1, 7'h06}, 8'h0f, 1'b1);
        flags(7'b0100010);
        check(16'(working_wdata), 16'h0000);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0000001);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0000000);
    endtask : t_skip_zero

    // A frozen cycle between a taken skip and its follower keeps both the pulses and the squash.
    task automatic t_freeze;
        put({OPC_DEC_SKIP, 1'b1, 7'h03}, 8'h01, 1'b1);
        put({OPC_COMPLEMENT, 1'b0, 7'h03}, 8'h0f, 1'b1);
        ce <= 1'b0;
        flags(7'b1000010);
        check(16'(file_wdata), 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        flags(7'b1000010);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0000001);
    endtask : t_freeze

    // The follower comes straight after the branch; only that one slot is squashed.
    task automatic t_branch_direct;
        put({OPC_BRANCH, 11'h123}, 8'h00, 1'b1);
        program_counter_upper_latch <= 8'h08;
        put({OPC_CLEAR, 1'b0, 7'h00}, 8'h00, 1'b1);
        flags(7'b0000110);
        check(16'(program_counter), 16'h0923);
        put(14'h0000, 8'h00, 1'b1);
        flags(7'b0000001);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0000000);
        check(16'(program_counter), 16'h0923);
    endtask : t_branch_direct

    // The follower comes after an idle slot and must still be squashed.
    task automatic t_branch(input logic [LIT_W-1:0] lit, input logic [LATCH_W-1:0] latch,
            input logic [PC_W-1:0] exp_pc);
        put({OPC_BRANCH, lit}, 8'h00, 1'b1);
        program_counter_upper_latch <= latch;
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0000110);
        check(16'(program_counter), 16'(exp_pc));
        put({OPC_DECREMENT, 1'b1, 7'h01}, 8'h09, 1'b1);
        flags(7'b0000000);
        put(14'h0000, 8'h00, 1'b0);
        flags(7'b0000001);
        check(16'(program_counter), 16'(exp_pc));
    endtask : t_branch

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        ce = 1'b1;
        instr_valid = 1'b0;
        instr = 14'h0000;
        file_rdata = 8'h00;
        program_counter_upper_latch = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        flags(7'b0000000);
        check(16'(program_counter), 16'h0000);
        t_complement();
        t_clear();
        t_decrement();
        t_skip_nonzero();
        t_skip_zero();
        t_branch(11'h7ff, 8'h18, 13'h1fff);
        t_branch(11'h000, 8'he7, 13'h0000);
        t_branch(11'h555, 8'h10, 13'h1555);
        t_freeze();
        t_branch_direct();
        close_out();
    end
endmodule : test_byte_op_and_branch_exec
`default_nettype wire
